// ---- rsil_pkg.sv ----
// Constants for the receive status and interrupt logic
package rsil_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_HDLC_STATUS = 10'h094;
  localparam logic [9:0] IDX_CODE_STATUS = 10'h096;
  localparam logic [9:0] IDX_SIG_STATUS_1 = 10'h098;
  localparam logic [9:0] IDX_SIG_STATUS_2 = 10'h099;
  localparam logic [9:0] IDX_SIG_STATUS_3 = 10'h09A;
  localparam logic [9:0] IDX_SIG_STATUS_4 = 10'h09B;
  localparam logic [9:0] IDX_SPARE_1 = 10'h09C;
  localparam logic [9:0] IDX_SPARE_2 = 10'h09D;
  localparam logic [9:0] IDX_SUMMARY = 10'h09F;
  localparam logic [9:0] IDX_ALARM_MASK = 10'h0A0;
  localparam logic [9:0] IDX_E1_MASK = 10'h0A1;
  localparam logic [9:0] IDX_HDLC_MASK = 10'h0A4;
  localparam logic [9:0] IDX_CODE_MASK = 10'h0A6;
  localparam logic [9:0] IDX_SIG_ENABLE_1 = 10'h0A8;
  localparam logic [9:0] IDX_SIG_ENABLE_2 = 10'h0A9;
  localparam logic [9:0] IDX_SIG_ENABLE_3 = 10'h0AA;
  localparam logic [9:0] IDX_SIG_ENABLE_4 = 10'h0AB;
  localparam logic [9:0] IDX_SA_SELECT = 10'h0B0;
  localparam logic [9:0] IDX_SPARE_LENGTH = 10'h0B1;

  // ==========================================================================
  // HDLC status bit positions
  localparam int HB_OVERFLOW = 5;
  localparam int HB_FIRST_BYTE = 4;
  localparam int HB_PKT_FINISH = 3;
  localparam int HB_PKT_BEGIN = 2;
  localparam int HB_HIGH_FILL = 1;
  localparam int HB_NONEMPTY = 0;

  // ==========================================================================
  // Code and Sa status bit positions (T1 / E1)
  localparam int CB_REMOTE_CI = 5;
  localparam int CB_BLUE_CI = 4;
  localparam int CB_LOOP_ALIGN = 3;
  localparam int CB_LINK_FULL = 2;
  localparam int CB_CODE_LOST = 1;
  localparam int CB_CODE_FOUND = 0;
  localparam int CB_SA_SIX = 1;
  localparam int CB_SA_CHANGE = 0;

  // ==========================================================================
  // Summary bit positions
  localparam int SB_ONE = 0;
  localparam int SB_TWO = 1;
  localparam int SB_THREE = 2;
  localparam int SB_FOUR = 3;
  localparam int SB_HDLC = 4;
  localparam int SB_CODE = 6;

  // ==========================================================================
  // Reset values and timing
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_SPARE_LEN = 4'hF;
  localparam int CLK_MHZ = 200;
  localparam int MF_D4_US = 1500;
  localparam int MF_ESF_US = 3000;
  localparam int MF_E1_US = 2000;
  localparam int MF_D4_CYCLES = MF_D4_US * CLK_MHZ;
  localparam int MF_ESF_CYCLES = MF_ESF_US * CLK_MHZ;
  localparam int MF_E1_CYCLES = MF_E1_US * CLK_MHZ;

endpackage

// ---- rsil_top.sv ----
// Receive status, signaling change and interrupt summary logic with APB access
//
// Behaviour
// R1: T1 multiframe event every 1.5/3 ms.
// R2: E1 multiframe event every 2 ms.
// R3: Latch overflow flag when FIFO full aborts.
// R4: Latch first-byte flag at FIFO output.
// R5: Latch packet finish on done or fault.
// R6: Latch packet begin; read clears it.
// R7: Latch high fill on rising level.
// R8: Latch nonempty on rising FIFO occupancy.
// R9: Remote CI flag only ESF with alarm.
// R10: Blue CI flag only with AIS present.
// R11: Latch loop carrier alignment with data ready.
// R12: Latch data link full flag.
// R13: Latch code found and code lost.
// R14: E1 Sa6 codeword flag latched.
// R15: E1 Sa change on selected bits.
// R16: Per-channel signaling change bits, read clears.
// R17: Enabled changes raise event; masked interrupt.
// R18: T1 pattern-1 write restarts integration.
// R19: Pattern from bit 7, length masks rest.
// R20: Summary bit per interrupting status register.
// R21: Summary clears when nothing unmasked remains.
// R22: Alarm mask bit 1 enables, 0 masks.
// R23: Interrupt low while any status&mask pair.
`timescale 1ns/1ps
module rsil_top #(
  parameter int MF_D4_CYCLES = rsil_pkg::MF_D4_CYCLES,
  parameter int MF_ESF_CYCLES = rsil_pkg::MF_ESF_CYCLES,
  parameter int MF_E1_CYCLES = rsil_pkg::MF_E1_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Framing mode
  input wire logic e1_mode,
  input wire logic esf_mode,
  input wire logic cas_enable,
  input wire logic mf_sync,
  // HDLC receiver
  input wire logic fifo_overflow,
  input wire logic first_message_byte,
  input wire logic packet_done,
  input wire logic packet_fault,
  input wire logic packet_begin,
  input wire logic high_fill_level,
  input wire logic fifo_holds_data,
  // T1 code detectors
  input wire logic remote_alarm_ci_seen,
  input wire logic remote_alarm_present,
  input wire logic blue_alarm_ci_seen,
  input wire logic blue_alarm_present,
  input wire logic loop_carrier_align_seen,
  input wire logic loop_carrier_data_ready,
  input wire logic data_link_full,
  input wire logic code_valid,
  // E1 Sa bits
  input wire logic sa_six_codeword_seen,
  input wire logic [4:0] sa_bits,
  input wire logic sa_bits_valid,
  // Signaling extractor
  input wire logic [31:0] channel_sig_change,
  // Other status registers
  input wire logic [7:0] latched_status_one,
  input wire logic [3:0] e1_status_two,
  input wire logic status_three_pending,
  input wire logic latched_status_four_pending,
  // Events and outputs
  output logic multiframe_boundary_event,
  output logic signaling_change_event,
  output logic [15:0] spare_code_pattern,
  output logic spare_code_restart,
  output logic interrupt_out_n
);

  typedef struct packed {
    logic [7:0] hdlc_st;
    logic [7:0] code_st;
    logic [31:0] sig_st;
    logic [7:0] hdlc_mask;
    logic [7:0] code_mask;
    logic [7:0] alarm_mask;
    logic [7:0] e1_mask;
    logic [31:0] sig_en;
    logic [7:0] spare1;
    logic [7:0] spare2;
    logic [3:0] spare_len;
    logic [7:0] sa_sel;
    logic [4:0] sa_prev;
    logic fill_prev;
    logic holds_prev;
    logic code_prev;
    logic [19:0] mf_cnt;
    logic mf_evt;
    logic sig_evt;
    logic restart;
    logic [15:0] pattern;
    logic [7:0] summary;
    logic irq_n;
    logic [31:0] rdata;
  } rsil_state_t;

  localparam rsil_state_t RESET_STATE = '{spare_len: rsil_pkg::RESET_SPARE_LEN,
                                          irq_n: 1'b1, default: '0};

  rsil_state_t s_q;
  rsil_state_t s_d;
  logic [9:0] idx;
  logic rd_acc;
  logic wr_acc;
  logic [19:0] period;

  // ==========================================================================
  // Address decode
  function automatic logic rsil_mapped(input logic [9:0] i);
    case (i)
      rsil_pkg::IDX_HDLC_STATUS, rsil_pkg::IDX_CODE_STATUS,
      rsil_pkg::IDX_SIG_STATUS_1, rsil_pkg::IDX_SIG_STATUS_2,
      rsil_pkg::IDX_SIG_STATUS_3, rsil_pkg::IDX_SIG_STATUS_4,
      rsil_pkg::IDX_SPARE_1, rsil_pkg::IDX_SPARE_2, rsil_pkg::IDX_SUMMARY,
      rsil_pkg::IDX_ALARM_MASK, rsil_pkg::IDX_E1_MASK, rsil_pkg::IDX_HDLC_MASK,
      rsil_pkg::IDX_CODE_MASK, rsil_pkg::IDX_SIG_ENABLE_1, rsil_pkg::IDX_SIG_ENABLE_2,
      rsil_pkg::IDX_SIG_ENABLE_3, rsil_pkg::IDX_SIG_ENABLE_4, rsil_pkg::IDX_SA_SELECT,
      rsil_pkg::IDX_SPARE_LENGTH: rsil_mapped = 1'b1;
      default: rsil_mapped = 1'b0;
    endcase
  endfunction

  assign idx = paddr[11:2];
  assign rd_acc = psel & penable & ~pwrite;
  assign wr_acc = psel & penable & pwrite & rsil_mapped(idx);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rsil_mapped(idx);
  assign period = e1_mode ? 20'(MF_E1_CYCLES) : (esf_mode ? 20'(MF_ESF_CYCLES) : 20'(MF_D4_CYCLES));

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.mf_evt = 1'b0;
    s_d.sig_evt = 1'b0;
    s_d.restart = 1'b0;

    // Multiframe timing, realigned by the framer's boundary unless E1 without CAS
    if ((mf_sync & (~e1_mode | cas_enable)) | (s_q.mf_cnt >= period - 20'h00001)) begin // see R1 see R2
      s_d.mf_cnt = '0;
      s_d.mf_evt = 1'b1;
    end else begin
      s_d.mf_cnt = s_q.mf_cnt + 20'h00001;
    end

    // Read clears only the bits that the read returned
    if (rd_acc) begin
      case (idx)
        rsil_pkg::IDX_HDLC_STATUS: s_d.hdlc_st = s_q.hdlc_st & ~s_q.rdata[7:0]; // see R5 see R6
        rsil_pkg::IDX_CODE_STATUS: s_d.code_st = s_q.code_st & ~s_q.rdata[7:0];
        rsil_pkg::IDX_SIG_STATUS_1: s_d.sig_st[7:0] = s_q.sig_st[7:0] & ~s_q.rdata[7:0]; // see R16
        rsil_pkg::IDX_SIG_STATUS_2: s_d.sig_st[15:8] = s_q.sig_st[15:8] & ~s_q.rdata[7:0];
        rsil_pkg::IDX_SIG_STATUS_3: s_d.sig_st[23:16] = s_q.sig_st[23:16] & ~s_q.rdata[7:0];
        rsil_pkg::IDX_SIG_STATUS_4: s_d.sig_st[31:24] = s_q.sig_st[31:24] & ~s_q.rdata[7:0];
        default: s_d.rdata = s_q.rdata;
      endcase
    end

    // HDLC events; sets come after clears so they win
    s_d.fill_prev = high_fill_level;
    s_d.holds_prev = fifo_holds_data;
    if (fifo_overflow) s_d.hdlc_st[rsil_pkg::HB_OVERFLOW] = 1'b1; // see R3
    if (first_message_byte) s_d.hdlc_st[rsil_pkg::HB_FIRST_BYTE] = 1'b1; // see R4
    if (packet_done | packet_fault) s_d.hdlc_st[rsil_pkg::HB_PKT_FINISH] = 1'b1; // see R5
    if (packet_begin) s_d.hdlc_st[rsil_pkg::HB_PKT_BEGIN] = 1'b1; // see R6
    if (high_fill_level & ~s_q.fill_prev) s_d.hdlc_st[rsil_pkg::HB_HIGH_FILL] = 1'b1; // see R7
    if (fifo_holds_data & ~s_q.holds_prev) s_d.hdlc_st[rsil_pkg::HB_NONEMPTY] = 1'b1; // see R8

    // T1 code events or E1 Sa events
    s_d.code_prev = code_valid;
    if (sa_bits_valid) s_d.sa_prev = sa_bits;
    if (!e1_mode) begin
      if (remote_alarm_ci_seen & esf_mode & remote_alarm_present) begin // see R9
        s_d.code_st[rsil_pkg::CB_REMOTE_CI] = 1'b1;
      end
      if (blue_alarm_ci_seen & blue_alarm_present) begin // see R10
        s_d.code_st[rsil_pkg::CB_BLUE_CI] = 1'b1;
      end
      if (loop_carrier_align_seen & loop_carrier_data_ready) begin // see R11
        s_d.code_st[rsil_pkg::CB_LOOP_ALIGN] = 1'b1;
      end
      if (data_link_full) s_d.code_st[rsil_pkg::CB_LINK_FULL] = 1'b1; // see R12
      if (~code_valid & s_q.code_prev) s_d.code_st[rsil_pkg::CB_CODE_LOST] = 1'b1; // see R13
      if (code_valid & ~s_q.code_prev) s_d.code_st[rsil_pkg::CB_CODE_FOUND] = 1'b1; // see R13
    end else begin
      if (sa_six_codeword_seen) s_d.code_st[rsil_pkg::CB_SA_SIX] = 1'b1; // see R14
      if (sa_bits_valid & |((sa_bits ^ s_q.sa_prev) & s_q.sa_sel[4:0])) begin // see R15
        s_d.code_st[rsil_pkg::CB_SA_CHANGE] = 1'b1;
      end
    end

    // Signaling changes; the fourth group exists in E1 only
    s_d.sig_st = s_d.sig_st | (channel_sig_change & {{8{e1_mode}}, 24'hFFFFFF}); // see R16
    s_d.sig_evt = |(channel_sig_change & s_q.sig_en & {{8{e1_mode}}, 24'hFFFFFF}); // see R17

    // Register writes
    if (wr_acc) begin
      case (idx)
        rsil_pkg::IDX_SPARE_1: begin
          s_d.spare1 = pwdata[7:0];
          s_d.restart = ~e1_mode; // see R18
        end
        rsil_pkg::IDX_SPARE_2: s_d.spare2 = pwdata[7:0];
        rsil_pkg::IDX_ALARM_MASK: s_d.alarm_mask = pwdata[7:0];
        rsil_pkg::IDX_E1_MASK: s_d.e1_mask = {4'h0, pwdata[3:0]};
        rsil_pkg::IDX_HDLC_MASK: s_d.hdlc_mask = {2'h0, pwdata[5:0]};
        rsil_pkg::IDX_CODE_MASK: s_d.code_mask = {2'h0, pwdata[5:0]};
        rsil_pkg::IDX_SIG_ENABLE_1: s_d.sig_en[7:0] = pwdata[7:0];
        rsil_pkg::IDX_SIG_ENABLE_2: s_d.sig_en[15:8] = pwdata[7:0];
        rsil_pkg::IDX_SIG_ENABLE_3: s_d.sig_en[23:16] = pwdata[7:0];
        rsil_pkg::IDX_SIG_ENABLE_4: s_d.sig_en[31:24] = pwdata[7:0];
        rsil_pkg::IDX_SA_SELECT: s_d.sa_sel = {3'h0, pwdata[4:0]};
        rsil_pkg::IDX_SPARE_LENGTH: s_d.spare_len = pwdata[3:0];
        default: s_d.spare2 = s_q.spare2;
      endcase
    end

    // Pattern starts at bit 7 of the first register; length field holds length minus one
    s_d.pattern = {s_d.spare1, s_d.spare2} & ~(16'h7FFF >> s_d.spare_len); // see R19

    // Summary: one bit per status register with an unmasked bit set
    s_d.summary = '0;
    s_d.summary[rsil_pkg::SB_ONE] = |(latched_status_one & s_d.alarm_mask); // see R20 see R22
    s_d.summary[rsil_pkg::SB_TWO] = e1_mode & |(e1_status_two & s_d.e1_mask[3:0]); // see R20
    s_d.summary[rsil_pkg::SB_THREE] = status_three_pending;
    s_d.summary[rsil_pkg::SB_FOUR] = latched_status_four_pending; // see R17
    s_d.summary[rsil_pkg::SB_HDLC] = |(s_d.hdlc_st & s_d.hdlc_mask); // see R21
    s_d.summary[rsil_pkg::SB_CODE] = |(s_d.code_st & s_d.code_mask); // see R21
    s_d.irq_n = ~|s_d.summary; // see R23

    // Read data is captured in the setup phase and held through the access phase
    if (psel & ~penable) begin
      case (idx)
        rsil_pkg::IDX_HDLC_STATUS: s_d.rdata = {24'h0, s_d.hdlc_st};
        rsil_pkg::IDX_CODE_STATUS: s_d.rdata = {24'h0, s_d.code_st};
        rsil_pkg::IDX_SIG_STATUS_1: s_d.rdata = {24'h0, s_d.sig_st[7:0]};
        rsil_pkg::IDX_SIG_STATUS_2: s_d.rdata = {24'h0, s_d.sig_st[15:8]};
        rsil_pkg::IDX_SIG_STATUS_3: s_d.rdata = {24'h0, s_d.sig_st[23:16]};
        rsil_pkg::IDX_SIG_STATUS_4: s_d.rdata = {24'h0, s_d.sig_st[31:24]};
        rsil_pkg::IDX_SPARE_1: s_d.rdata = {24'h0, s_d.spare1};
        rsil_pkg::IDX_SPARE_2: s_d.rdata = {24'h0, s_d.spare2};
        rsil_pkg::IDX_SUMMARY: s_d.rdata = {24'h0, s_d.summary};
        rsil_pkg::IDX_ALARM_MASK: s_d.rdata = {24'h0, s_d.alarm_mask};
        rsil_pkg::IDX_E1_MASK: s_d.rdata = {24'h0, s_d.e1_mask};
        rsil_pkg::IDX_HDLC_MASK: s_d.rdata = {24'h0, s_d.hdlc_mask};
        rsil_pkg::IDX_CODE_MASK: s_d.rdata = {24'h0, s_d.code_mask};
        rsil_pkg::IDX_SIG_ENABLE_1: s_d.rdata = {24'h0, s_d.sig_en[7:0]};
        rsil_pkg::IDX_SIG_ENABLE_2: s_d.rdata = {24'h0, s_d.sig_en[15:8]};
        rsil_pkg::IDX_SIG_ENABLE_3: s_d.rdata = {24'h0, s_d.sig_en[23:16]};
        rsil_pkg::IDX_SIG_ENABLE_4: s_d.rdata = {24'h0, s_d.sig_en[31:24]};
        rsil_pkg::IDX_SA_SELECT: s_d.rdata = {24'h0, s_d.sa_sel};
        rsil_pkg::IDX_SPARE_LENGTH: s_d.rdata = {28'h0, s_d.spare_len};
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign multiframe_boundary_event = s_q.mf_evt;
  assign signaling_change_event = s_q.sig_evt;
  assign spare_code_pattern = s_q.pattern;
  assign spare_code_restart = s_q.restart;
  assign interrupt_out_n = s_q.irq_n;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hdlc_read;
    rd_acc && idx == rsil_pkg::IDX_HDLC_STATUS;
  endsequence

  sequence s_rise(sig);
    !sig ##1 sig;
  endsequence

  property p_overflow;
    fifo_overflow |=> s_q.hdlc_st[rsil_pkg::HB_OVERFLOW];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag not latched"); // see R3

  property p_first_byte;
    first_message_byte |=> s_q.hdlc_st[rsil_pkg::HB_FIRST_BYTE];
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("first byte flag missed"); // see R4

  property p_finish;
    (packet_done || packet_fault) |=> s_q.hdlc_st[rsil_pkg::HB_PKT_FINISH];
  endproperty
  a_finish: assert property (p_finish) else $error("packet finish flag missed"); // see R5

  property p_begin_clear;
    (s_hdlc_read and (s_q.rdata[rsil_pkg::HB_PKT_BEGIN] && !packet_begin))
      |=> !s_q.hdlc_st[rsil_pkg::HB_PKT_BEGIN];
  endproperty
  a_begin_clear: assert property (p_begin_clear) else $error("packet begin not cleared"); // see R6

  property p_high_fill;
    s_rise(high_fill_level) |=> s_q.hdlc_st[rsil_pkg::HB_HIGH_FILL];
  endproperty
  a_high_fill: assert property (p_high_fill) else $error("high fill edge missed"); // see R7

  property p_nonempty;
    s_rise(fifo_holds_data) |=> s_q.hdlc_st[rsil_pkg::HB_NONEMPTY];
  endproperty
  a_nonempty: assert property (p_nonempty) else $error("nonempty edge missed"); // see R8

  property p_remote_ci;
    (remote_alarm_ci_seen && !(esf_mode && remote_alarm_present) && !e1_mode &&
     !s_q.code_st[rsil_pkg::CB_REMOTE_CI]) |=> !s_q.code_st[rsil_pkg::CB_REMOTE_CI];
  endproperty
  a_remote_ci: assert property (p_remote_ci) else $error("remote CI set without alarm"); // see R9

  property p_code_lost;
    (!e1_mode && code_valid ##1 !e1_mode && !code_valid) |=> s_q.code_st[rsil_pkg::CB_CODE_LOST];
  endproperty
  a_code_lost: assert property (p_code_lost) else $error("code lost flag missed"); // see R13

  property p_sig_event;
    |(channel_sig_change[23:0] & s_q.sig_en[23:0]) |=> signaling_change_event;
  endproperty
  a_sig_event: assert property (p_sig_event) else $error("signaling event missed"); // see R17

  property p_multiframe;
    s_q.mf_cnt >= period - 20'h00001 |=> multiframe_boundary_event;
  endproperty
  a_multiframe: assert property (p_multiframe) else $error("multiframe period missed"); // see R1

  // Framer boundary realigns the count in T1, and in E1 only with CAS on
  property p_mf_sync;
    mf_sync && (!e1_mode || cas_enable)
      |=> multiframe_boundary_event && s_q.mf_cnt == 20'h00000;
  endproperty
  a_mf_sync: assert property (p_mf_sync) else $error("multiframe sync not followed"); // see R2

  property p_code_found;
    (!e1_mode && !code_valid ##1 !e1_mode && code_valid)
      |=> s_q.code_st[rsil_pkg::CB_CODE_FOUND];
  endproperty
  a_code_found: assert property (p_code_found) else $error("code found flag missed"); // see R13

  property p_restart;
    (wr_acc && idx == rsil_pkg::IDX_SPARE_1 && !e1_mode) |=> spare_code_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("spare restart missing"); // see R18

  property p_irq;
    |(s_q.hdlc_st & s_q.hdlc_mask) |-> !interrupt_out_n && s_q.summary[rsil_pkg::SB_HDLC];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not driven"); // see R23

endmodule // rsil_top

// ---- rsil_host.sv ----
// Host-side APB master model with one register transfer task
`timescale 1ns/1ps
module rsil_host (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // ==========================================================================
  // One transfer, held until pready is sampled high or the bound runs out
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
    output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines carry no stale request
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // rsil_host

// ---- test_receive_status_interrupt_logic.sv ----
// Self-checking testbench for the receive status and interrupt logic
`timescale 1ns/1ps
module test_receive_status_interrupt_logic;
  // ==========================================================================
  // Signals
  localparam int D4 = 30;
  localparam int ESF = 60;
  localparam int E1P = 40;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, mfe, sce, scr, irq_n, e, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [31:0] chg = '0;
  logic [11:0] pv = '0;
  logic e1 = 1'b0, esf = 1'b0, cas = 1'b0, hfl = 1'b0, fhd = 1'b0, rap = 1'b0, bap = 1'b0;
  logic ldr = 1'b0, cv = 1'b0, p3 = 1'b0, p4 = 1'b0;
  logic [4:0] sab = '0;
  logic [3:0] st2 = '0;
  logic [7:0] st1 = '0;
  logic [15:0] scp;
  int miscompares = 0, n_checks = 0, cyc = 0, mf_last = 0, mf_gap = 0, sce_n = 0, restarts = 0;
  logic [9:0] ridx [0:10] = '{rsil_pkg::IDX_HDLC_STATUS, rsil_pkg::IDX_CODE_STATUS,
    rsil_pkg::IDX_SIG_STATUS_1, rsil_pkg::IDX_SIG_STATUS_2, rsil_pkg::IDX_SIG_STATUS_3,
    rsil_pkg::IDX_SIG_STATUS_4, rsil_pkg::IDX_SPARE_1, rsil_pkg::IDX_SPARE_2,
    rsil_pkg::IDX_SUMMARY, rsil_pkg::IDX_ALARM_MASK, rsil_pkg::IDX_E1_MASK};

  always #2.5 pclk = ~pclk;

  // Event monitors: multiframe spacing and pulse counts
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (mfe === 1'b1) begin
      mf_gap <= cyc - mf_last;
      mf_last <= cyc;
    end
    if (sce === 1'b1) sce_n <= sce_n + 1;
    if (scr === 1'b1) restarts <= restarts + 1;
  end

  rsil_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  rsil_top #(.MF_D4_CYCLES(D4), .MF_ESF_CYCLES(ESF), .MF_E1_CYCLES(E1P)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .e1_mode(e1), .esf_mode(esf), .cas_enable(cas), .mf_sync(pv[11]),
    .fifo_overflow(pv[0]), .first_message_byte(pv[1]), .packet_done(pv[2]),
    .packet_fault(pv[3]), .packet_begin(pv[4]), .high_fill_level(hfl), .fifo_holds_data(fhd),
    .remote_alarm_ci_seen(pv[5]), .remote_alarm_present(rap), .blue_alarm_ci_seen(pv[6]),
    .blue_alarm_present(bap), .loop_carrier_align_seen(pv[7]), .loop_carrier_data_ready(ldr),
    .data_link_full(pv[8]), .code_valid(cv), .sa_six_codeword_seen(pv[9]), .sa_bits(sab),
    .sa_bits_valid(pv[10]), .channel_sig_change(chg), .latched_status_one(st1),
    .e1_status_two(st2), .status_three_pending(p3), .latched_status_four_pending(p4),
    .multiframe_boundary_event(mfe), .signaling_change_event(sce),
    .spare_code_pattern(scp), .spare_code_restart(scr), .interrupt_out_n(irq_n));

  // ==========================================================================
  // Tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    host.xfer(wr, idx, wd, d, e, ok);
    if (!ok) begin
      chk("pready", 32'h1, 32'h0);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    acc(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk($sformatf("register %h", idx), {24'h000000, exp}, d);
  endtask

  task automatic pulse(input logic [11:0] b);
    @(posedge pclk);
    pv <= b;
    @(posedge pclk);
    pv <= '0;
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    tick(6);
    presetn <= 1'b1;
    tick(1);
    chk("irq idle", 32'h1, {31'h0, irq_n});
    foreach (ridx[i]) rd(ridx[i], 8'h00);
    acc(1'b0, 10'h09E, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    wr(rsil_pkg::IDX_SUMMARY, 8'hFF);
    rd(rsil_pkg::IDX_SUMMARY, 8'h00);
    // HDLC flags, read clear and edge-only level flags
    wr(rsil_pkg::IDX_HDLC_MASK, 8'h3F);
    pulse(12'h017);
    hfl <= 1'b1;
    fhd <= 1'b1;
    tick(2);
    chk("irq active", 32'h0, {31'h0, irq_n});
    rd(rsil_pkg::IDX_SUMMARY, 8'h10);
    rd(rsil_pkg::IDX_HDLC_STATUS, 8'h3F);
    rd(rsil_pkg::IDX_HDLC_STATUS, 8'h00);
    rd(rsil_pkg::IDX_SUMMARY, 8'h00);
    chk("irq released", 32'h1, {31'h0, irq_n});
    pulse(12'h008);
    rd(rsil_pkg::IDX_HDLC_STATUS, 8'h08);
    wr(rsil_pkg::IDX_HDLC_MASK, 8'h00);
    pulse(12'h010);
    rd(rsil_pkg::IDX_SUMMARY, 8'h00);
    chk("irq masked", 32'h1, {31'h0, irq_n});
    rd(rsil_pkg::IDX_HDLC_STATUS, 8'h04);
    // Alarm mask, one bit at a time
    for (int b = 0; b < 8; b++) begin
      st1 <= 8'h01 << b;
      wr(rsil_pkg::IDX_ALARM_MASK, 8'h01 << b);
      rd(rsil_pkg::IDX_SUMMARY, 8'h01);
      wr(rsil_pkg::IDX_ALARM_MASK, ~(8'h01 << b));
      rd(rsil_pkg::IDX_SUMMARY, 8'h00);
    end
    st1 <= 8'h00;
    st2 <= 4'h2;
    p3 <= 1'b1;
    p4 <= 1'b1;
    wr(rsil_pkg::IDX_E1_MASK, 8'h02);
    rd(rsil_pkg::IDX_SUMMARY, 8'h0C);
    e1 <= 1'b1;
    rd(rsil_pkg::IDX_SUMMARY, 8'h0E);
    e1 <= 1'b0;
    st2 <= 4'h0;
    p3 <= 1'b0;
    p4 <= 1'b0;
    // T1 code flags with and without their qualifiers
    esf <= 1'b1;
    wr(rsil_pkg::IDX_CODE_MASK, 8'h3F);
    pulse(12'h0E0);
    rd(rsil_pkg::IDX_CODE_STATUS, 8'h00);
    rap <= 1'b1;
    bap <= 1'b1;
    ldr <= 1'b1;
    pulse(12'h1E0);
    cv <= 1'b1;
    tick(2);
    cv <= 1'b0;
    tick(2);
    rd(rsil_pkg::IDX_SUMMARY, 8'h40);
    rd(rsil_pkg::IDX_CODE_STATUS, 8'h3F);
    esf <= 1'b0;
    pulse(12'h020);
    rd(rsil_pkg::IDX_CODE_STATUS, 8'h00);
    // E1 Sa flags
    e1 <= 1'b1;
    wr(rsil_pkg::IDX_SA_SELECT, 8'h01);
    pulse(12'h400);
    acc(1'b0, rsil_pkg::IDX_CODE_STATUS, 8'h00);
    sab <= 5'h02;
    pulse(12'h400);
    rd(rsil_pkg::IDX_CODE_STATUS, 8'h00);
    sab <= 5'h03;
    pulse(12'h400);
    rd(rsil_pkg::IDX_CODE_STATUS, 8'h01);
    pulse(12'h200);
    rd(rsil_pkg::IDX_CODE_STATUS, 8'h02);
    // Signaling change bits and enabled event
    e1 <= 1'b0;
    wr(rsil_pkg::IDX_SIG_ENABLE_1, 8'h01);
    chg <= 32'h0100_0201;
    tick(1);
    chg <= '0;
    tick(2);
    chk("signaling events", 32'h1, sce_n);
    rd(rsil_pkg::IDX_SIG_STATUS_1, 8'h01);
    rd(rsil_pkg::IDX_SIG_STATUS_2, 8'h02);
    rd(rsil_pkg::IDX_SIG_STATUS_4, 8'h00);
    rd(rsil_pkg::IDX_SIG_STATUS_1, 8'h00);
    e1 <= 1'b1;
    chg <= 32'h0100_0000;
    tick(1);
    chg <= '0;
    rd(rsil_pkg::IDX_SIG_STATUS_4, 8'h01);
    // Spare code pattern per length, restart on pattern 1 writes in T1
    e1 <= 1'b0;
    for (int n = 1; n <= 8; n++) begin
      wr(rsil_pkg::IDX_SPARE_LENGTH, 8'(n - 1));
      wr(rsil_pkg::IDX_SPARE_1, 8'hFF);
      wr(rsil_pkg::IDX_SPARE_2, 8'hFF);
      tick(2);
      chk("spare pattern", {16'h0000, 8'hFF << (8 - n), 8'h00}, {16'h0000, scp});
    end
    wr(rsil_pkg::IDX_SPARE_LENGTH, 8'h0F);
    tick(2);
    chk("spare pattern full", 32'h0000_FFFF, {16'h0000, scp});
    rd(rsil_pkg::IDX_SPARE_1, 8'hFF);
    e1 <= 1'b1;
    wr(rsil_pkg::IDX_SPARE_1, 8'h0F);
    tick(2);
    chk("spare restarts", 32'h8, restarts);
    // Multiframe spacing in each mode
    tick(3 * E1P);
    chk("E1 multiframe gap", E1P, mf_gap);
    e1 <= 1'b0;
    tick(3 * D4);
    chk("D4 multiframe gap", D4, mf_gap);
    esf <= 1'b1;
    tick(3 * ESF);
    chk("ESF multiframe gap", ESF, mf_gap);
    // Two framer boundaries two cycles apart realign the count each time
    pulse(12'h800);
    pulse(12'h800);
    tick(2);
    chk("T1 sync gap", 32'h2, mf_gap);
    e1 <= 1'b1;
    cas <= 1'b1;
    pulse(12'h800);
    pulse(12'h800);
    tick(2);
    chk("E1 CAS sync gap", 32'h2, mf_gap);
    wrap_up();
  end
endmodule // test_receive_status_interrupt_logic
